// *** hw/ascs_pkg.sv ***
// Shared constants for the amplifier soft-control sequencer ends
package ascs_pkg;
  // Control port register offsets
  localparam logic [7:0] ASCS_REG_CTRL = 8'h01;
  localparam logic [7:0] ASCS_REG_VOLUME = 8'h04;
  localparam logic [7:0] ASCS_REG_MUTE = 8'h07;
  localparam logic [7:0] ASCS_REG_STATUS = 8'h08;
  localparam logic [7:0] ASCS_REG_CLIP_HIGH = 8'h10;
  localparam logic [7:0] ASCS_REG_CLIP_LOW = 8'h11;
  localparam logic [7:0] ASCS_REG_CLIP_TOP = 8'h12;
  // Field layout
  localparam int ASCS_CLIP_W = 20;
  localparam int ASCS_SAMPLE_W = 24;
  localparam int ASCS_LOW_LSB = 2;
  localparam int ASCS_HIGH_LSB = 6;
  localparam int ASCS_TOP_LSB = 14;
  localparam logic [1:0] ASCS_LOW_RSV = 2'h0;
  localparam logic [7:0] ASCS_BIT_ON = 8'h01;
  localparam logic [7:0] ASCS_BIT_OFF = 8'h00;
  // Reset values
  localparam logic [7:0] ASCS_VOLUME_RST = 8'h80;
  localparam logic [7:0] ASCS_CLIP_HIGH_RST = 8'hff;
  localparam logic [7:0] ASCS_CLIP_LOW_RST = 8'hfc;
  localparam logic [5:0] ASCS_CLIP_TOP_RST = 6'h3f;
  // Timing
  localparam int ASCS_CLK_PERIOD_NS = 8;
  localparam int ASCS_SETTLE_NS = 1000;
  localparam int ASCS_SETTLE_CYC = (ASCS_SETTLE_NS + ASCS_CLK_PERIOD_NS - 1) / ASCS_CLK_PERIOD_NS;
  localparam int ASCS_WAIT_W = 12;
  localparam logic [2:0] ASCS_CFG_LAST = 3'h4;
endpackage

// *** hw/ascs_if.sv ***
// Link between host sequencer and amplifier control logic
`timescale 1ns/1ps
interface ascs_if;
  logic amp_shutdown_n; // Shutdown pin, low holds amplifier off
  logic master_clock; // Audio clocks from host
  logic bit_clock;
  logic frame_clock;
  logic cp_wr; // Control port write pulse
  logic cp_rd; // Control port read pulse
  logic [7:0] cp_addr;
  logic [7:0] cp_wdata;
  logic [7:0] cp_rdata;
  logic cp_ack; // One-cycle answer pulse
  modport host_mp (
    output amp_shutdown_n, master_clock, bit_clock, frame_clock,
    output cp_wr, cp_rd, cp_addr, cp_wdata,
    input cp_rdata, cp_ack
  );
  modport device_mp (
    input amp_shutdown_n, master_clock, bit_clock, frame_clock,
    input cp_wr, cp_rd, cp_addr, cp_wdata,
    output cp_rdata, cp_ack
  );
endinterface

// *** hw/ascs_device.sv ***
// Amplifier end: control registers, shutdown gating and output clipper
`timescale 1ns/1ps
module ascs_device (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link to host
  ascs_if.device_mp link,
  // Audio sample from the serial port
  input wire logic signed [ascs_pkg::ASCS_SAMPLE_W-1:0] sample_in,
  // Speaker stage
  output logic signed [ascs_pkg::ASCS_SAMPLE_W-1:0] spk_sample,
  output logic spk_active,
  output logic [7:0] volume,
  output logic [ascs_pkg::ASCS_CLIP_W-1:0] clip_threshold_level
);
  import ascs_pkg::*;

  logic sd_s1_q, sd_s2_q, fc_s1_q, fc_s2_q, fc_prev_q; // Pin synchronisers
  logic ctrl_on_q, ctrl_on_d; // Software shutdown bit, 1 = running
  logic mute_q, mute_d;
  logic [7:0] vol_q, vol_d;
  logic [7:0] high_q, high_d;
  logic [7:0] low_q, low_d; // Bits 1:0 stored as written
  logic [5:0] top_q, top_d;
  logic [7:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic signed [ASCS_SAMPLE_W-1:0] spk_q, spk_d;
  logic act_q, act_d;
  logic shutdown, silent, frame_edge, wr_ok;
  logic [ASCS_CLIP_W-1:0] thr;
  logic signed [ASCS_SAMPLE_W-1:0] thr_s, clipped;

  // Two flops on the shutdown and frame clock pins from the host before any logic looks at them
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sd_s1_q <= 1'b0;
      sd_s2_q <= 1'b0;
      fc_s1_q <= 1'b0;
      fc_s2_q <= 1'b0;
      fc_prev_q <= 1'b0;
    end else begin
      sd_s1_q <= link.amp_shutdown_n;
      sd_s2_q <= sd_s1_q;
      fc_s1_q <= link.frame_clock;
      fc_s2_q <= fc_s1_q;
      fc_prev_q <= fc_s2_q;
    end
  end

  // Either the pin or the control bit places the device in shutdown
  assign shutdown = !sd_s2_q || !ctrl_on_q;
  assign silent = shutdown || mute_q;
  assign frame_edge = fc_s2_q && !fc_prev_q;
  // Threshold assembled from three fields
  assign thr = {top_q, high_q, low_q[7:ASCS_LOW_LSB]};
  assign thr_s = signed'({{(ASCS_SAMPLE_W-ASCS_CLIP_W){1'b0}}, thr});
  // Symmetric clip; the result never exceeds the programmed level
  assign clipped = (sample_in > thr_s) ? thr_s :
                   (sample_in < -thr_s) ? -thr_s : sample_in;
  // Volume and mute stay writable in operation so the host can
  // mute and unmute around shutdown; everything else waits for it
  assign wr_ok = shutdown || (link.cp_addr == ASCS_REG_VOLUME) ||
                 (link.cp_addr == ASCS_REG_MUTE);

  // Register file and speaker path next values
  always_comb begin
    ctrl_on_d = ctrl_on_q;
    mute_d = mute_q;
    vol_d = vol_q;
    high_d = high_q;
    low_d = low_q;
    top_d = top_q;
    rdata_d = rdata_q;
    ack_d = link.cp_wr || link.cp_rd;
    spk_d = spk_q;
    act_d = !silent;
    if (link.cp_wr && wr_ok) begin
      unique case (link.cp_addr)
        ASCS_REG_CTRL: ctrl_on_d = link.cp_wdata[0];
        ASCS_REG_MUTE: mute_d = link.cp_wdata[0];
        ASCS_REG_VOLUME: vol_d = link.cp_wdata;
        ASCS_REG_CLIP_HIGH: high_d = link.cp_wdata;
        ASCS_REG_CLIP_LOW: low_d = link.cp_wdata;
        ASCS_REG_CLIP_TOP: top_d = link.cp_wdata[5:0];
        default: ; // Unmapped writes are dropped
      endcase
    end
    if (link.cp_rd) begin
      unique case (link.cp_addr)
        ASCS_REG_CTRL: rdata_d = {7'h00, ctrl_on_q};
        ASCS_REG_MUTE: rdata_d = {7'h00, mute_q};
        ASCS_REG_VOLUME: rdata_d = vol_q;
        ASCS_REG_STATUS: rdata_d = {5'h00, act_q, mute_q, shutdown};
        ASCS_REG_CLIP_HIGH: rdata_d = high_q;
        ASCS_REG_CLIP_LOW: rdata_d = low_q;
        ASCS_REG_CLIP_TOP: rdata_d = {2'h0, top_q};
        default: rdata_d = 8'h00; // Unmapped reads return zero
      endcase
    end
    // Silence at once; new samples only on a frame edge
    if (silent) begin
      spk_d = '0;
    end else if (frame_edge) begin
      spk_d = clipped;
    end
  end

  // Register the control and speaker state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_on_q <= 1'b0;
      mute_q <= 1'b1;
      vol_q <= ASCS_VOLUME_RST;
      high_q <= ASCS_CLIP_HIGH_RST;
      low_q <= ASCS_CLIP_LOW_RST;
      top_q <= ASCS_CLIP_TOP_RST;
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
      spk_q <= '0;
      act_q <= 1'b0;
    end else begin
      ctrl_on_q <= ctrl_on_d;
      mute_q <= mute_d;
      vol_q <= vol_d;
      high_q <= high_d;
      low_q <= low_d;
      top_q <= top_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      spk_q <= spk_d;
      act_q <= act_d;
    end
  end

  assign link.cp_rdata = rdata_q;
  assign link.cp_ack = ack_q;
  assign spk_sample = spk_q;
  assign spk_active = act_q;
  assign volume = vol_q;
  assign clip_threshold_level = thr;
endmodule // ascs_device

// *** hw/ascs_host.sv ***
// Host end: power, clock, configuration and shutdown sequencing
`timescale 1ns/1ps
module ascs_host #(
  parameter int SETTLE_CYC = ascs_pkg::ASCS_SETTLE_CYC, // Clock and pin settle
  parameter int DIV_W = 8 // Frame clock is clk_sys over 2**DIV_W
) (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link to amplifier
  ascs_if.host_mp link,
  // Supply control
  input wire logic power_good,
  output logic power_enable,
  // Sequencing requests, one-cycle pulses, and the threshold level to configure
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic [ascs_pkg::ASCS_CLIP_W-1:0] clip_threshold_level,
  // Volume write in operation
  input wire logic vol_req,
  input wire logic [7:0] vol_value,
  // Register read in operation
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Status
  output logic running,
  output logic powered_off
);
  import ascs_pkg::*;

  typedef enum logic [9:0] {
    H_OFF = 10'h001, // Unpowered, pin low, clocks off
    H_PWR = 10'h002, // Supplies enabled, waiting for good
    H_CLK = 10'h004, // Clocks running, settling
    H_CFG = 10'h008, // Writing configuration while muted
    H_REL = 10'h010, // Shutdown pin released, settling
    H_UNMUTE = 10'h020, // Clearing mute
    H_RUN = 10'h040, // Normal operation
    H_MUTE = 10'h080, // Muting before shutdown
    H_SDLOW = 10'h100, // Shutdown pin low, settling
    H_STOP = 10'h200 // Clocks and supplies coming down
  } ascs_state_type;

  localparam logic [ASCS_WAIT_W-1:0] SETTLE_LOAD = ASCS_WAIT_W'(SETTLE_CYC);

  ascs_state_type state_q, state_d;
  logic [2:0] step_q, step_d; // Configuration write index
  logic [ASCS_WAIT_W-1:0] wait_q, wait_d; // Settle countdown
  logic busy_q, busy_d; // A control port access is outstanding
  logic is_rd_q, is_rd_d; // Outstanding access is a read
  logic wr_q, wr_d, rd_q, rd_d;
  logic [7:0] addr_q, addr_d, wdata_q, wdata_d;
  logic sd_n_q, sd_n_d; // Drives the shutdown pin
  logic clk_on_q, clk_on_d; // Gates the audio clocks
  logic pwr_q, pwr_d;
  logic [7:0] rdat_q, rdat_d;
  logic rvld_q, rvld_d;
  logic run_q, run_d, off_q, off_d;
  logic pg_s1_q, pg_s2_q; // Supply-good synchroniser
  logic [DIV_W-1:0] div_q, div_d;
  logic mclk_q, mclk_d, bclk_q, bclk_d, fclk_q, fclk_d;
  logic ack_ev, can_issue;
  logic [7:0] cfg_addr, cfg_data;

  // Supply-good comes from off-chip, so it is synchronised first
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pg_s1_q <= 1'b0;
      pg_s2_q <= 1'b0;
    end else begin
      pg_s1_q <= power_good;
      pg_s2_q <= pg_s1_q;
    end
  end

  // Audio clock divider; the clocks are plain outputs of flops
  always_comb begin
    div_d = div_q + 1'b1;
    mclk_d = clk_on_q && div_q[0];
    bclk_d = clk_on_q && div_q[2];
    fclk_d = clk_on_q && div_q[DIV_W-1];
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= '0;
      mclk_q <= 1'b0;
      bclk_q <= 1'b0;
      fclk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      mclk_q <= mclk_d;
      bclk_q <= bclk_d;
      fclk_q <= fclk_d;
    end
  end

  // Configuration writes; mute goes in before anything else
  always_comb begin
    cfg_addr = ASCS_REG_MUTE;
    cfg_data = ASCS_BIT_ON;
    case (step_q)
      3'h0: begin
        cfg_addr = ASCS_REG_MUTE;
        cfg_data = ASCS_BIT_ON;
      end
      3'h1: begin
        cfg_addr = ASCS_REG_CLIP_TOP;
        cfg_data = {2'h0, clip_threshold_level[ASCS_CLIP_W-1:ASCS_TOP_LSB]};
      end
      3'h2: begin
        cfg_addr = ASCS_REG_CLIP_HIGH;
        cfg_data = clip_threshold_level[ASCS_TOP_LSB-1:ASCS_HIGH_LSB];
      end
      3'h3: begin
        cfg_addr = ASCS_REG_CLIP_LOW;
        // Reserved low bits always written as their default
        cfg_data = {clip_threshold_level[ASCS_HIGH_LSB-1:0], ASCS_LOW_RSV};
      end
      3'h4: begin
        cfg_addr = ASCS_REG_CTRL;
        cfg_data = ASCS_BIT_ON;
      end
      default: begin
        cfg_addr = ASCS_REG_MUTE; // Unused step codes rewrite mute
        cfg_data = ASCS_BIT_ON;
      end
    endcase
  end

  // An answer only counts while an access is outstanding
  assign ack_ev = link.cp_ack && busy_q;
  // One access at a time; a new one waits for the previous answer
  assign can_issue = !busy_q;

  // Sequencer next values
  always_comb begin
    state_d = state_q;
    step_d = step_q;
    wait_d = wait_q;
    busy_d = busy_q;
    is_rd_d = is_rd_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    sd_n_d = sd_n_q;
    clk_on_d = clk_on_q;
    pwr_d = pwr_q;
    rdat_d = rdat_q;
    rvld_d = 1'b0;
    if (ack_ev) begin
      busy_d = 1'b0;
      if (is_rd_q) begin
        rdat_d = link.cp_rdata;
        rvld_d = 1'b1;
      end
    end
    unique case (state_q)
      H_OFF: begin
        sd_n_d = 1'b0;
        if (start_req) begin
          pwr_d = 1'b1;
          state_d = H_PWR;
        end
      end
      H_PWR: begin
        // Clocks wait for stable supplies
        if (pg_s2_q) begin
          clk_on_d = 1'b1;
          wait_d = SETTLE_LOAD;
          state_d = H_CLK;
        end
      end
      H_CLK: begin
        // Configuration waits for settled clocks
        if (wait_q == '0) begin
          step_d = 3'h0;
          state_d = H_CFG;
        end else begin
          wait_d = wait_q - 1'b1;
        end
      end
      H_CFG: begin
        if (ack_ev) begin
          if (step_q == ASCS_CFG_LAST) begin
            state_d = H_REL;
            wait_d = SETTLE_LOAD;
          end else begin
            step_d = step_q + 1'b1;
          end
        end else if (can_issue) begin
          wr_d = 1'b1;
          busy_d = 1'b1;
          is_rd_d = 1'b0;
          addr_d = cfg_addr;
          wdata_d = cfg_data;
        end
      end
      H_REL: begin
        sd_n_d = 1'b1;
        if (wait_q == '0) begin
          state_d = H_UNMUTE;
        end else begin
          wait_d = wait_q - 1'b1;
        end
      end
      H_UNMUTE: begin
        if (ack_ev) begin
          state_d = H_RUN;
        end else if (can_issue) begin
          wr_d = 1'b1;
          busy_d = 1'b1;
          is_rd_d = 1'b0;
          addr_d = ASCS_REG_MUTE;
          wdata_d = ASCS_BIT_OFF;
        end
      end
      H_RUN: begin
        // Only volume is written here; a stop is taken only while the port is idle
        if (can_issue && stop_req) begin
          state_d = H_MUTE;
        end else if (can_issue && vol_req) begin
          wr_d = 1'b1;
          busy_d = 1'b1;
          is_rd_d = 1'b0;
          addr_d = ASCS_REG_VOLUME;
          wdata_d = vol_value;
        end else if (can_issue && rd_req) begin
          rd_d = 1'b1;
          busy_d = 1'b1;
          is_rd_d = 1'b1;
          addr_d = rd_addr;
        end
      end
      H_MUTE: begin
        if (ack_ev) begin
          wait_d = SETTLE_LOAD;
          state_d = H_SDLOW;
        end else if (can_issue) begin
          wr_d = 1'b1;
          busy_d = 1'b1;
          is_rd_d = 1'b0;
          addr_d = ASCS_REG_MUTE;
          wdata_d = ASCS_BIT_ON;
        end
      end
      H_SDLOW: begin
        sd_n_d = 1'b0;
        if (wait_q == '0) begin
          wait_d = SETTLE_LOAD;
          state_d = H_STOP;
        end else begin
          wait_d = wait_q - 1'b1;
        end
      end
      H_STOP: begin
        // Clocks and supplies drop only with the pin already low
        clk_on_d = 1'b0;
        if (wait_q == '0) begin
          pwr_d = 1'b0;
          state_d = H_OFF;
        end else begin
          wait_d = wait_q - 1'b1;
        end
      end
      default: begin
        state_d = H_OFF; // Recover from a corrupted state code
        sd_n_d = 1'b0;
      end
    endcase
    run_d = (state_d == H_RUN);
    off_d = (state_d == H_OFF) && !pwr_d;
  end

  // Register the sequencer state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= H_OFF;
      step_q <= 3'h0;
      wait_q <= '0;
      busy_q <= 1'b0;
      is_rd_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      sd_n_q <= 1'b0;
      clk_on_q <= 1'b0;
      pwr_q <= 1'b0;
      rdat_q <= 8'h00;
      rvld_q <= 1'b0;
      run_q <= 1'b0;
      off_q <= 1'b1;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      wait_q <= wait_d;
      busy_q <= busy_d;
      is_rd_q <= is_rd_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      sd_n_q <= sd_n_d;
      clk_on_q <= clk_on_d;
      pwr_q <= pwr_d;
      rdat_q <= rdat_d;
      rvld_q <= rvld_d;
      run_q <= run_d;
      off_q <= off_d;
    end
  end

  assign link.amp_shutdown_n = sd_n_q;
  assign link.master_clock = mclk_q;
  assign link.bit_clock = bclk_q;
  assign link.frame_clock = fclk_q;
  assign link.cp_wr = wr_q;
  assign link.cp_rd = rd_q;
  assign link.cp_addr = addr_q;
  assign link.cp_wdata = wdata_q;
  assign power_enable = pwr_q;
  assign rd_data = rdat_q;
  assign rd_valid = rvld_q;
  assign running = run_q;
  assign powered_off = off_q;
endmodule // ascs_host

// *** test/ascs_checker.sv ***
// Protocol checker for the host to amplifier control link
`timescale 1ns/1ps
module ascs_checker (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link signals
  input wire logic amp_shutdown_n,
  input wire logic master_clock,
  input wire logic bit_clock,
  input wire logic frame_clock,
  input wire logic cp_wr,
  input wire logic cp_rd,
  input wire logic [7:0] cp_addr,
  input wire logic [7:0] cp_wdata,
  input wire logic [7:0] cp_rdata,
  input wire logic cp_ack
);
  import ascs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic mute_seen_q; // Last mute value written over the port
  logic mute_seen_d;
  logic ctrl_seen_q; // Last shutdown control bit written
  logic ctrl_seen_d;
  // Shadow of the mute and control bits, as the device should hold them
  always_comb begin
    mute_seen_d = mute_seen_q;
    ctrl_seen_d = ctrl_seen_q;
    if (cp_wr && cp_addr == ASCS_REG_MUTE) begin
      mute_seen_d = cp_wdata[0];
    end
    if (cp_wr && cp_addr == ASCS_REG_CTRL) begin
      ctrl_seen_d = cp_wdata[0];
    end
  end
  // Reset values match the device: muted and in shutdown
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mute_seen_q <= 1'b1;
      ctrl_seen_q <= 1'b0;
    end else begin
      mute_seen_q <= mute_seen_d;
      ctrl_seen_q <= ctrl_seen_d;
    end
  end
  a_ack_follows_access: assert property ((cp_wr || cp_rd) |=> cp_ack)
    else $error("no answer one cycle after access");
  a_ack_has_cause: assert property (cp_ack |-> $past(cp_wr || cp_rd) ##1 !cp_ack)
    else $error("answer without access or longer than one cycle");
  a_clocks_before_cfg: assert property (cp_wr |-> master_clock != $past(master_clock))
    else $error("control write while clocks stopped");
  a_low_reserved_zero: assert property (
    (cp_wr && cp_addr == ASCS_REG_CLIP_LOW) |-> cp_wdata[1:0] == ASCS_LOW_RSV)
    else $error("reserved threshold bits written nonzero");
  a_cfg_in_shutdown: assert property ((cp_wr && cp_addr != ASCS_REG_VOLUME &&
    cp_addr != ASCS_REG_MUTE) |-> !amp_shutdown_n)
    else $error("configuration write outside shutdown");
  a_release_muted_cfg: assert property ($rose(amp_shutdown_n) |-> mute_seen_q && ctrl_seen_q)
    else $error("shutdown released before mute and configuration");
  a_unmute_after_release: assert property (
    (cp_wr && cp_addr == ASCS_REG_MUTE && !cp_wdata[0]) |-> amp_shutdown_n)
    else $error("unmute while still in shutdown");
  a_mute_before_shutdown: assert property ($fell(amp_shutdown_n) |-> mute_seen_q)
    else $error("shutdown entered while unmuted");
  a_clocks_while_on: assert property (
    (amp_shutdown_n && $past(amp_shutdown_n)) |-> master_clock != $past(master_clock))
    else $error("clocks stopped while out of shutdown");
  // Audio clocks share one divider, so a frame step must carry the faster clocks
  a_frame_with_bits: assert property (
    (amp_shutdown_n && $changed(frame_clock)) |->
    $changed(bit_clock) && $changed(master_clock))
    else $error("frame clock moved without bit and master clocks");
  // Read-back of mute must show the last value written over the port
  a_mute_readback: assert property ((cp_rd && cp_addr == ASCS_REG_MUTE) |=>
    cp_rdata == (mute_seen_q ? ASCS_BIT_ON : ASCS_BIT_OFF))
    else $error("mute read-back differs from last write");
  c_release: cover property ($rose(amp_shutdown_n));
  c_enter_shutdown: cover property ($fell(amp_shutdown_n));
  c_low_write: cover property (cp_wr && cp_addr == ASCS_REG_CLIP_LOW);
  c_read: cover property (cp_rd ##1 cp_ack);
endmodule // ascs_checker

// *** test/testbench.sv ***
// Self-checking bench joining host and amplifier ends over one link
`timescale 1ns/1ps
module testbench;
  import ascs_pkg::*;
  logic clk_sys; // 125 MHz system clock
  logic sys_rst;
  logic power_good, power_enable, start_req, stop_req, vol_req, rd_req, rd_valid;
  logic running, powered_off, spk_active;
  logic [ASCS_CLIP_W-1:0] thr, dev_thr; // Programmed and decoded threshold
  logic [7:0] vol_value, rd_addr, rd_data, volume, v;
  logic signed [ASCS_SAMPLE_W-1:0] sample_in, spk_sample;
  logic [31:0] rng_q = 32'h00000058; // Xorshift state
  logic [23:0] exp_q[$]; // Expected read answers, oldest first
  int error_cnt = 0;
  int n_compared = 0;
  int i;
  ascs_if link();
  // Short settle and fast frame clock keep the run brief
  ascs_host #(.SETTLE_CYC(4), .DIV_W(4)) i_ascs_host (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .power_good(power_good),
    .power_enable(power_enable), .start_req(start_req), .stop_req(stop_req),
    .clip_threshold_level(thr), .vol_req(vol_req), .vol_value(vol_value), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .running(running),
    .powered_off(powered_off));
  ascs_device i_ascs_device (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .sample_in(sample_in),
    .spk_sample(spk_sample), .spk_active(spk_active), .volume(volume),
    .clip_threshold_level(dev_thr));
  ascs_checker i_ascs_checker (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .amp_shutdown_n(link.amp_shutdown_n),
    .master_clock(link.master_clock), .bit_clock(link.bit_clock),
    .frame_clock(link.frame_clock), .cp_wr(link.cp_wr), .cp_rd(link.cp_rd),
    .cp_addr(link.cp_addr), .cp_wdata(link.cp_wdata), .cp_rdata(link.cp_rdata),
    .cp_ack(link.cp_ack));
  function logic [31:0] xs();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Register read through the host, answer noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    rd_req = 1'b1;
    rd_addr = a;
    exp_q.push_back({16'h0000, e});
    @(negedge clk_sys);
    rd_req = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  // Drive one sample and look at the speaker after a few frames
  task automatic clip(input logic [23:0] s, input logic [23:0] e);
    @(negedge clk_sys);
    sample_in = s;
    repeat (48) @(negedge clk_sys);
    check(spk_sample, e);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Supplies report good half a cycle after they are enabled, bench side
  always @(negedge clk_sys) begin
    power_good <= power_enable;
  end
  // Monitor: every read answer is matched with the oldest note
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(24'hffffff, {16'h0000, rd_data});
      end else begin
        check({16'h0000, rd_data}, exp_q.pop_front());
      end
    end
  end
  // Watchdog: the full sequence needs well under this many cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    // Supply-good is owned by its own process, so it is not set here
    {start_req, stop_req, vol_req, rd_req} = 4'h0;
    vol_value = 8'h00;
    rd_addr = 8'h00;
    sample_in = 24'h000000;
    thr = 20'h00000;
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    check(link.amp_shutdown_n, 1'b0);
    check(powered_off, 1'b1);
    // Two full power cycles, each with a new threshold and volume
    repeat (2) begin
      thr = 20'(xs()) | 20'h00010;
      @(negedge clk_sys);
      start_req = 1'b1;
      @(negedge clk_sys);
      start_req = 1'b0;
      check(spk_active, 1'b0);
      for (i = 0; i < 3000 && running !== 1'b1; i++) @(negedge clk_sys);
      repeat (4) @(negedge clk_sys);
      check(running, 1'b1);
      check(link.amp_shutdown_n, 1'b1);
      check(dev_thr, thr);
      rd(ASCS_REG_CLIP_LOW, {thr[5:0], 2'h0});
      rd(ASCS_REG_CLIP_HIGH, thr[13:6]);
      rd(ASCS_REG_CLIP_TOP, {2'h0, thr[19:14]});
      rd(ASCS_REG_MUTE, ASCS_BIT_OFF);
      rd(ASCS_REG_CTRL, ASCS_BIT_ON);
      rd(ASCS_REG_STATUS, 8'h04);
      rd(8'h0a, 8'h00);
      // Volume is the one setting the host writes while playing
      v = 8'(xs());
      @(negedge clk_sys);
      vol_req = 1'b1;
      vol_value = v;
      @(negedge clk_sys);
      vol_req = 1'b0;
      repeat (4) @(negedge clk_sys);
      check(volume, v);
      rd(ASCS_REG_VOLUME, v);
      clip(24'h7fffff, {4'h0, thr});
      clip(24'h800000, -{4'h0, thr});
      clip({5'h00, thr[19:1]}, {5'h00, thr[19:1]});
      @(negedge clk_sys);
      stop_req = 1'b1;
      @(negedge clk_sys);
      stop_req = 1'b0;
      for (i = 0; i < 3000 && powered_off !== 1'b1; i++) @(negedge clk_sys);
      check(powered_off, 1'b1);
      check(link.amp_shutdown_n, 1'b0);
      check(link.master_clock, 1'b0);
      check(power_enable, 1'b0);
      check(spk_sample, 24'h000000);
      check(spk_active, 1'b0);
    end
    check(24'(exp_q.size()), 24'h000000);
    print_verdict();
  end
endmodule // testbench
